//--- core/smd_defines.svh
/*
  Constants for the sector-map entry and the factory delivery image.
  Assumes inclusion by bare name from the package and the design module.
*/
`ifndef SMD_DEFINES_SVH
`define SMD_DEFINES_SVH

// Parameter-space byte addresses of the final map entry
`define SMD_HDR_ADDR      8'ha8
`define SMD_REGION_ADDR   8'hac
`define SMD_DWORD_BYTES   4
// Header fields
`define SMD_HDR_RSVD      6'h3f
`define SMD_HDR_DESC      1'b1
`define SMD_HDR_END       1'b1
`define SMD_CFG_ID        8'h05
`define SMD_REGION_CNT    8'h00
`define SMD_RSVD_BYTE     8'hff
// Region fields
`define SMD_SIZE_128      24'h00ffff
`define SMD_SIZE_256      24'h01ffff
`define SMD_ERASE_RSVD    4'hf
`define SMD_ERASE_TYPES   4'h4
// Factory image
`define SMD_ERASED        8'hff
`define SMD_OTP_RANDOM    10'h010
`define SMD_STATUS1_INIT  8'h00
`define SMD_CFG1_INIT     8'h00
`define SMD_CFG2_INIT     8'h08
`define SMD_CFG3_INIT     8'h00
`define SMD_CFG4_INIT     8'h10
`define SMD_PASSWORD_INIT 40'hff_ffff_ffff
`define SMD_GUARD_INIT    16'hffff
`define SMD_LOCK_BITS     128
// Register-space byte indexes
`define SMD_REG_STATUS1   5'h00
`define SMD_REG_CFG1      5'h01
`define SMD_REG_CFG2      5'h02
`define SMD_REG_CFG3      5'h03
`define SMD_REG_CFG4      5'h04
`define SMD_REG_PASSWORD  5'h05
`define SMD_REG_GUARD     5'h0a
`define SMD_REG_LAST      5'h0b

`endif

//--- core/smd_pkg.sv
/*
  Types for the sector-map and factory-default block.
  Assumes smd_defines.svh is on the include path.
*/
`include "smd_defines.svh"

package smd_pkg;

  typedef enum logic [1:0] {
    SPACE_PARAM,
    SPACE_ARRAY,
    SPACE_OTP,
    SPACE_REGS
  } smd_space_e;

  typedef struct packed {
    logic       valid;
    smd_space_e space;
    logic [24:0] addr;
  } smd_req_s;

  typedef struct packed {
    logic [7:0]  status1;
    logic [7:0]  cfg1;
    logic [7:0]  cfg2;
    logic [7:0]  cfg3;
    logic [7:0]  cfg4;
    logic [39:0] password;
    logic [15:0] guard;
    logic [`SMD_LOCK_BITS-1:0] lockBits;
  } smd_nv_s;

  typedef struct packed {
    logic       rdValid;
    logic       rdHit;
    logic [7:0] rdData;
    smd_nv_s    nv;
  } smd_state_s;

endpackage

//--- core/smd_factory_rom.sv
/*
  Read-only view of the final sector-map entry and of the factory delivery
  state of array, one-time-program area and non-volatile registers.
  Four spaces share one byte request port: parameter space, main array,
  one-time-program area and register image. Every answer is one byte.
  The image is loaded by reset and never written, so every read is pure
  decoding; the only state is the answer register and the held image.
  Assumes a command decoder outside presents one byte request per cycle,
  synchronous to clock, and takes the byte one cycle later.
  Assumes the density strap is stable while a request is taken.
  Assumes reset is asserted once before the first request.
*/
// How it works
// - Header byte 2 (bits 23:16) is region count 00h: one region.
// - Header byte 1 (bits 15:8) is configuration id 05h: uniform 256-kbyte sectors.
// - Header byte 0 has bits 7:2 set, bit 1 map descriptor set and bit 0 end marker set.
// - Region bits 31:8 hold size in 256-byte units minus one: 00FFFFh or 01FFFFh by density.
// - Region bits 7:4 are ones, bit 2 set for 256-kbyte erase, bits 3, 1 and 0 clear.
// - Every main array byte reads FFh.
// - The first 16 one-time-program bytes hold a random value and the rest read FFh.
// - The non-volatile first status register powers up as 00h.
// - Non-volatile configuration registers one to four hold 00h, 08h, 00h and 10h.
// - The password register holds all ones.
// - All per-sector lock bits are 1 and the guard word reads FFFFh.
`timescale 1ns/1ps
`include "smd_defines.svh"

module smd_factory_rom #(
  parameter logic [127:0] OTP_RANDOM = 128'h5a3c_96e1_0f78_2bd4_c167_e93a_4d05_b8f2 // Arbitrary value
) (
  input  wire logic                       clock,
  input  wire logic                       reset,
  input  wire logic                       density256,
  input  wire smd_pkg::smd_req_s          rdReq,
  output      logic                       rdValid,
  output      logic                       rdHit,
  output      logic [7:0]                 rdData,
  output      smd_pkg::smd_nv_s           nvImage
);

  smd_pkg::smd_state_s s_r;
  smd_pkg::smd_state_s s_nxt;

  // Header dword of the final map entry, as a 32-bit word
  // Low byte is all ones: reserved bits, descriptor flag and end marker
  function automatic logic [31:0] headerWord();
    headerWord = {`SMD_RSVD_BYTE, `SMD_REGION_CNT, `SMD_CFG_ID,
                  `SMD_HDR_RSVD, `SMD_HDR_DESC, `SMD_HDR_END};
  endfunction

  // Region dword; size depends on the density strap
  // Size counts 256-byte units minus one; only the top byte moves with density
  function automatic logic [31:0] regionWord(input logic big);
    regionWord = {(big ? `SMD_SIZE_256 : `SMD_SIZE_128),
                  `SMD_ERASE_RSVD, `SMD_ERASE_TYPES};
  endfunction

  // Final map entry occupies two dword slots of the parameter space
  function automatic logic isHeader(input logic [24:0] addr);
    isHeader = (addr[24:2] == 23'(`SMD_HDR_ADDR >> 2));
  endfunction

  function automatic logic isRegion(input logic [24:0] addr);
    isRegion = (addr[24:2] == 23'(`SMD_REGION_ADDR >> 2));
  endfunction

  // Byte of the parameter space; unmapped bytes read erased and miss
  // Lane picks the byte inside the dword, lowest lane first on the wire
  function automatic logic [8:0] paramByte(input logic [24:0] addr, input logic big);
    logic [31:0] word;
    logic [1:0]  lane;
    word = 32'h0;
    lane = addr[1:0];
    if (isHeader(addr)) begin
      word = headerWord();
    end else if (isRegion(addr)) begin
      word = regionWord(big);
    end
    if (isHeader(addr) || isRegion(addr)) begin
      paramByte = {1'b1, word[8*lane +: 8]};
    end else begin
      paramByte = {1'b0, `SMD_ERASED};
    end
  endfunction

  // One-time-program area is 1024 bytes; anything above misses
  function automatic logic otpInside(input logic [24:0] addr);
    otpInside = (addr[24:10] == 15'h0);
  endfunction

  // One-time-program byte; the area wraps at 1024 bytes
  // Random head is a parameter; a real part holds a per-device value
  function automatic logic [7:0] otpByte(input logic [24:0] addr);
    if (addr[9:0] < `SMD_OTP_RANDOM) begin
      otpByte = OTP_RANDOM[8*addr[3:0] +: 8];
    end else begin
      otpByte = `SMD_ERASED;
    end
  endfunction

  // Register image byte; multi-byte registers low byte first
  // Index map: 0 status, 1 to 4 configuration, 5 to 9 password, 0Ah to 0Bh guard
  function automatic logic [8:0] regByte(input logic [24:0] addr, input smd_pkg::smd_nv_s nv);
    logic [4:0] idx;
    idx = addr[4:0];
    if (addr[24:5] != 20'h0 || idx > `SMD_REG_LAST) begin
      regByte = {1'b0, `SMD_ERASED};
    end else if (idx == `SMD_REG_STATUS1) begin
      regByte = {1'b1, nv.status1};
    end else if (idx == `SMD_REG_CFG1) begin
      regByte = {1'b1, nv.cfg1};
    end else if (idx == `SMD_REG_CFG2) begin
      regByte = {1'b1, nv.cfg2};
    end else if (idx == `SMD_REG_CFG3) begin
      regByte = {1'b1, nv.cfg3};
    end else if (idx == `SMD_REG_CFG4) begin
      regByte = {1'b1, nv.cfg4};
    // Password bytes, lowest byte at the lowest index
    end else if (idx < `SMD_REG_GUARD) begin
      regByte = {1'b1, nv.password[8*(idx - `SMD_REG_PASSWORD) +: 8]};
    end else begin
      // Guard word bytes, low byte first
      regByte = {1'b1, nv.guard[8*(idx - `SMD_REG_GUARD) +: 8]};
    end
  endfunction

  // Answer one cycle after the request; no writes exist, so the image holds
  // Hit and data refresh only on a taken request, so an idle port
  // keeps showing the last answer for a slow consumer
  always_comb begin
    logic [8:0] hitByte;
    hitByte = {1'b0, `SMD_ERASED};
    s_nxt = s_r;
    s_nxt.rdValid = rdReq.valid;
    // Space select is a full enum, so every code is decoded
    unique case (rdReq.space)
      smd_pkg::SPACE_PARAM: hitByte = paramByte(rdReq.addr, density256);
      smd_pkg::SPACE_ARRAY: hitByte = {1'b1, `SMD_ERASED};
      smd_pkg::SPACE_OTP:   hitByte = {otpInside(rdReq.addr), otpByte(rdReq.addr)};
      smd_pkg::SPACE_REGS:  hitByte = regByte(rdReq.addr, s_r.nv);
    endcase
    if (rdReq.valid) begin
      s_nxt.rdHit  = hitByte[8];
      s_nxt.rdData = hitByte[7:0];
    end
  end

  // Factory values are loaded by reset; a real part keeps them in cells
  // Image is never rewritten after this, which the image checks rely on
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_r             <= '0;
      s_r.rdData      <= `SMD_ERASED;
      s_r.nv.status1  <= `SMD_STATUS1_INIT;
      s_r.nv.cfg1     <= `SMD_CFG1_INIT;
      s_r.nv.cfg2     <= `SMD_CFG2_INIT;
      s_r.nv.cfg3     <= `SMD_CFG3_INIT;
      s_r.nv.cfg4     <= `SMD_CFG4_INIT;
      s_r.nv.password <= `SMD_PASSWORD_INIT;
      s_r.nv.guard    <= `SMD_GUARD_INIT;
      s_r.nv.lockBits <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from the state register
  assign rdValid = s_r.rdValid;
  assign rdHit   = s_r.rdHit;
  assign rdData  = s_r.rdData;
  assign nvImage = s_r.nv;

  // Checks on the parameter entry, main array, one-time-program tail and register image
  region_count_a: assert property (@(posedge clock) disable iff (reset)
    rdReq.valid && rdReq.space == smd_pkg::SPACE_PARAM && rdReq.addr == 25'(`SMD_HDR_ADDR + 2)
    |=> rdValid && rdHit && rdData == 8'h00) else $error("region count byte wrong");
  config_id_a: assert property (@(posedge clock) disable iff (reset)
    rdReq.valid && rdReq.space == smd_pkg::SPACE_PARAM && rdReq.addr == 25'(`SMD_HDR_ADDR + 1)
    |=> rdData == 8'h05) else $error("configuration id byte wrong");
  header_low_a: assert property (@(posedge clock) disable iff (reset)
    rdReq.valid && rdReq.space == smd_pkg::SPACE_PARAM && rdReq.addr == 25'(`SMD_HDR_ADDR)
    |=> rdData == 8'hff) else $error("header low byte wrong");
  region_size_a: assert property (@(posedge clock) disable iff (reset)
    rdReq.valid && rdReq.space == smd_pkg::SPACE_PARAM && rdReq.addr == 25'(`SMD_REGION_ADDR + 3)
    |=> rdData == ($past(density256) ? 8'h01 : 8'h00)) else $error("region size top byte wrong");
  erase_bits_a: assert property (@(posedge clock) disable iff (reset)
    rdReq.valid && rdReq.space == smd_pkg::SPACE_PARAM && rdReq.addr == 25'(`SMD_REGION_ADDR)
    |=> rdData == 8'hf4) else $error("erase support byte wrong");
  array_erased_a: assert property (@(posedge clock) disable iff (reset)
    rdReq.valid && rdReq.space == smd_pkg::SPACE_ARRAY |=> rdHit && rdData == 8'hff)
    else $error("array byte not erased");
  otp_tail_a: assert property (@(posedge clock) disable iff (reset)
    rdReq.valid && rdReq.space == smd_pkg::SPACE_OTP && rdReq.addr[9:4] != 6'h0
    |=> rdData == 8'hff) else $error("otp tail not erased");
  nv_image_a: assert property (@(posedge clock) disable iff (reset)
    nvImage.status1 == 8'h00 && nvImage.cfg1 == 8'h00 && nvImage.cfg2 == 8'h08
    && nvImage.cfg3 == 8'h00 && nvImage.cfg4 == 8'h10)
    else $error("register image wrong");
  guard_ones_a: assert property (@(posedge clock) disable iff (reset)
    &nvImage.password && nvImage.guard == 16'hffff && &nvImage.lockBits) else $error("protection image wrong");

  // Handshake: exactly one answer pulse per taken request and none otherwise
  // An idle port keeps its last answer, so a slow consumer may still read it
  // Without the hold, a consumer one cycle late would see a stale mix
  answer_pulse_a: assert property (@(posedge clock) disable iff (reset)
    rdReq.valid
    |=> rdValid)
    else $error("answer pulse missing");
  idle_quiet_a: assert property (@(posedge clock) disable iff (reset)
    !rdReq.valid
    |=> !rdValid)
    else $error("answer pulse without request");
  answer_holds_a: assert property (@(posedge clock) disable iff (reset)
    !rdReq.valid
    |=> $stable(rdData) && $stable(rdHit))
    else $error("answer changed while idle");

  // Rest of the map entry, byte by byte; the top header byte is reserved ones
  // Every byte of the entry must hit, or a host would see a hole in the table
  // Size bytes are checked per strap so a swapped strap shows at once
  header_top_a: assert property (@(posedge clock) disable iff (reset)
    rdReq.valid && rdReq.space == smd_pkg::SPACE_PARAM
    && rdReq.addr == 25'(`SMD_HDR_ADDR + 3)
    |=> rdHit && rdData == 8'hff)
    else $error("header top byte wrong");
  region_mid_a: assert property (@(posedge clock) disable iff (reset)
    rdReq.valid && rdReq.space == smd_pkg::SPACE_PARAM
    && (rdReq.addr == 25'(`SMD_REGION_ADDR + 1) || rdReq.addr == 25'(`SMD_REGION_ADDR + 2))
    |=> rdHit && rdData == 8'hff)
    else $error("region size middle bytes wrong");
  density_top_a: assert property (@(posedge clock) disable iff (reset)
    rdReq.valid && rdReq.space == smd_pkg::SPACE_PARAM && !density256
    && rdReq.addr == 25'(`SMD_REGION_ADDR + 3)
    |=> rdHit && rdData == 8'h00)
    else $error("small density size byte wrong");
  density_big_a: assert property (@(posedge clock) disable iff (reset)
    rdReq.valid && rdReq.space == smd_pkg::SPACE_PARAM && density256
    && rdReq.addr == 25'(`SMD_REGION_ADDR + 3)
    |=> rdHit && rdData == 8'h01)
    else $error("large density size byte wrong");
  param_hit_a: assert property (@(posedge clock) disable iff (reset)
    rdReq.valid && rdReq.space == smd_pkg::SPACE_PARAM
    && rdReq.addr >= 25'(`SMD_HDR_ADDR) && rdReq.addr <= 25'(`SMD_REGION_ADDR + 3)
    |=> rdHit)
    else $error("map entry byte missed");
  param_miss_a: assert property (@(posedge clock) disable iff (reset)
    rdReq.valid && rdReq.space == smd_pkg::SPACE_PARAM
    && (rdReq.addr < 25'(`SMD_HDR_ADDR) || rdReq.addr > 25'(`SMD_REGION_ADDR + 3))
    |=> !rdHit && rdData == 8'hff)
    else $error("unmapped parameter byte hit");

  // One-time-program area: head bytes are the stored random value, above 1024 misses
  // Mirrored data above the area is allowed; only the hit flag tells it apart
  // Head check indexes the parameter with the taken address, one cycle back
  otp_head_a: assert property (@(posedge clock) disable iff (reset)
    rdReq.valid && rdReq.space == smd_pkg::SPACE_OTP
    && rdReq.addr < 25'(`SMD_OTP_RANDOM)
    |=> rdHit && rdData == OTP_RANDOM[8*$past(rdReq.addr[3:0]) +: 8])
    else $error("otp head byte wrong");
  otp_hit_a: assert property (@(posedge clock) disable iff (reset)
    rdReq.valid && rdReq.space == smd_pkg::SPACE_OTP
    && rdReq.addr[24:10] == 15'h0
    |=> rdHit)
    else $error("otp byte missed");
  otp_miss_a: assert property (@(posedge clock) disable iff (reset)
    rdReq.valid && rdReq.space == smd_pkg::SPACE_OTP
    && rdReq.addr[24:10] != 15'h0
    |=> !rdHit)
    else $error("otp byte above area hit");

  // Register image as seen through the read port, low byte first
  // These watch the read path; the image itself is checked above
  // Indexes past the guard word must miss and read erased
  status_byte_a: assert property (@(posedge clock) disable iff (reset)
    rdReq.valid && rdReq.space == smd_pkg::SPACE_REGS
    && rdReq.addr == 25'(`SMD_REG_STATUS1)
    |=> rdHit && rdData == 8'h00)
    else $error("status byte wrong");
  cfg_zero_a: assert property (@(posedge clock) disable iff (reset)
    rdReq.valid && rdReq.space == smd_pkg::SPACE_REGS
    && (rdReq.addr == 25'(`SMD_REG_CFG1) || rdReq.addr == 25'(`SMD_REG_CFG3))
    |=> rdHit && rdData == 8'h00)
    else $error("configuration byte one or three wrong");
  cfg_two_a: assert property (@(posedge clock) disable iff (reset)
    rdReq.valid && rdReq.space == smd_pkg::SPACE_REGS
    && rdReq.addr == 25'(`SMD_REG_CFG2)
    |=> rdHit && rdData == 8'h08)
    else $error("configuration byte two wrong");
  cfg_four_a: assert property (@(posedge clock) disable iff (reset)
    rdReq.valid && rdReq.space == smd_pkg::SPACE_REGS
    && rdReq.addr == 25'(`SMD_REG_CFG4)
    |=> rdHit && rdData == 8'h10)
    else $error("configuration byte four wrong");
  password_bytes_a: assert property (@(posedge clock) disable iff (reset)
    rdReq.valid && rdReq.space == smd_pkg::SPACE_REGS
    && rdReq.addr >= 25'(`SMD_REG_PASSWORD) && rdReq.addr < 25'(`SMD_REG_GUARD)
    |=> rdHit && rdData == 8'hff)
    else $error("password byte wrong");
  guard_bytes_a: assert property (@(posedge clock) disable iff (reset)
    rdReq.valid && rdReq.space == smd_pkg::SPACE_REGS
    && rdReq.addr >= 25'(`SMD_REG_GUARD) && rdReq.addr <= 25'(`SMD_REG_LAST)
    |=> rdHit && rdData == 8'hff)
    else $error("guard byte wrong");
  regs_miss_a: assert property (@(posedge clock) disable iff (reset)
    rdReq.valid && rdReq.space == smd_pkg::SPACE_REGS
    && rdReq.addr > 25'(`SMD_REG_LAST)
    |=> !rdHit && rdData == 8'hff)
    else $error("register index past image hit");

  // Nothing writes the image, so any change after reset is a fault
  image_fixed_a: assert property (@(posedge clock) disable iff (reset)
    $stable(nvImage))
    else $error("factory image changed");

endmodule

//--- tb/smd_host_model.sv
/*
  Host-side requester for the factory read-only block: one byte request at a time.
  Assumes the block answers one cycle after it takes a request.
*/
`timescale 1ns/1ps

module smd_host_model (
  input  wire logic              clock,
  output      smd_pkg::smd_req_s rdReq,
  input  wire logic              rdValid,
  input  wire logic              rdHit,
  input  wire logic [7:0]        rdData
);
  initial rdReq = '0;

  // Request held one edge; the address is scrambled once released so stale values never help
  task automatic readByte(input smd_pkg::smd_space_e space, input logic [24:0] addr,
                          output logic hit, output logic [7:0] data, output logic seen);
    @(posedge clock);
    rdReq <= '{valid: 1'b1, space: space, addr: addr};
    @(posedge clock);
    rdReq <= '{valid: 1'b0, space: space, addr: ~addr};
    // Answer read mid-cycle, where the registered outputs have settled
    @(negedge clock);
    seen = rdValid;
    hit = rdHit;
    data = rdData;
  endtask
endmodule

//--- tb/sector_map_and_factory_defaults_bench.sv
/*
  Self-checking bench for the sector-map entry and factory image.
  Assumes the host model above and a 50 MHz clock.
*/
`timescale 1ns/1ps

module sector_map_and_factory_defaults_bench;
  localparam logic [127:0] OTP_VAL = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210; // Arbitrary value
  logic              clock;
  logic              reset;
  logic              density256;
  logic              rdValid;
  logic              rdHit;
  logic [7:0]        rdData;
  logic [7:0]        d;
  logic [127:0]      got;
  smd_pkg::smd_req_s rdReq;
  smd_pkg::smd_nv_s  nvImage;
  int                fail_count;
  int                n_checks;
  int                cycles;

  smd_factory_rom #(.OTP_RANDOM(OTP_VAL)) dut_u (.clock(clock), .reset(reset), .density256(density256),
    .rdReq(rdReq), .rdValid(rdValid), .rdHit(rdHit), .rdData(rdData), .nvImage(nvImage));
  smd_host_model host_u (.clock(clock), .rdReq(rdReq), .rdValid(rdValid), .rdHit(rdHit), .rdData(rdData));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One byte, with the answer pulse and hit flag checked on the way
  task automatic rd(input smd_pkg::smd_space_e sp, input logic [24:0] a, input logic eh, output logic [7:0] b);
    logic v, h;
    host_u.readByte(sp, a, h, b, v);
    check({v, h}, {1'b1, eh});
  endtask

  // Gathers n bytes at rising addresses, first byte lowest
  task automatic rdN(input smd_pkg::smd_space_e sp, input logic [24:0] a, input int n, output logic [127:0] v);
    logic [7:0] b;
    v = '0;
    for (int i = 0; i < n; i++) begin
      rd(sp, a + 25'(i), 1'b1, b);
      v[8*i+:8] = b;
    end
  endtask

  // Hang guard: the sequence needs about 110 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      test_done();
    end
  end

  initial begin
    reset = 1'b1;
    density256 = 1'b0;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    check({rdValid, rdHit, rdData}, 10'h0ff);
    check(nvImage.status1, 8'h00);
    check({nvImage.cfg1, nvImage.cfg2, nvImage.cfg3, nvImage.cfg4}, 32'h0008_0010);
    check(nvImage.password, 40'hff_ffff_ffff);
    check({nvImage.guard, &nvImage.lockBits}, 17'h1_ffff);
    rdN(smd_pkg::SPACE_REGS, 25'h0, 12, got);
    check(got[7:0], 8'h00);
    check(got[39:8], 32'h1000_0800);
    check(got[79:40], 40'hff_ffff_ffff);
    check(got[95:80], 16'hffff);
    rd(smd_pkg::SPACE_REGS, 25'h0c, 1'b0, d);
    check(d, 8'hff);
    // Both densities; only the top region byte may differ
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      density256 <= k[0];
      rdN(smd_pkg::SPACE_PARAM, 25'ha8, 8, got);
      check(got[31:0], 32'hff00_05ff);
      check(got[63:32], k ? 32'h01ff_fff4 : 32'h00ff_fff4);
    end
    rd(smd_pkg::SPACE_PARAM, 25'ha7, 1'b0, d);
    check(d, 8'hff);
    rd(smd_pkg::SPACE_ARRAY, 25'h0, 1'b1, d);
    check(d, 8'hff);
    rd(smd_pkg::SPACE_ARRAY, 25'h1ff_ffff, 1'b1, d);
    check(d, 8'hff);
    rdN(smd_pkg::SPACE_OTP, 25'h0, 16, got);
    check(got, OTP_VAL);
    rd(smd_pkg::SPACE_OTP, 25'h010, 1'b1, d);
    check(d, 8'hff);
    rd(smd_pkg::SPACE_OTP, 25'h3ff, 1'b1, d);
    check(d, 8'hff);
    rd(smd_pkg::SPACE_OTP, 25'h400, 1'b0, d);
    // Area mirrors above 3FFh; only the hit flag marks the miss
    check(d, OTP_VAL[7:0]);
    test_done();
  end
endmodule
